// ### hdl/scis_pkg.sv
package scis_pkg;
  localparam int DW = 32;
  localparam int IW = 16;
  localparam int NSTK = 8;
  localparam int SIW = 3;
  localparam int IM6_W = 6;
  localparam int IM4_W = 4;
  localparam int HALF_W = 16;
  // field positions
  localparam int A_LSB = 0;
  localparam int A_POP_BIT = 3;
  localparam int B_LSB = 4;
  localparam int B_POP_BIT = 7;
  localparam int IM8_LO_LSB = 0;
  localparam int IM8_HI_LSB = 4;
  localparam int IM6_LSB = 4;
  localparam int IM4_LSB = 8;
  localparam int MEM_HALF_BIT = 13;
  localparam int MEM_WR_BIT = 12;
  localparam int SK_TWO_BIT = 11;
  localparam int SK_U_BIT = 10;
  localparam int COND_L_BIT = 9;
  localparam int COND_N_BIT = 8;
  localparam int CJ8_L_BIT = 13;
  localparam int CJ8_N_BIT = 12;
  localparam int REG_W_BIT = 10;
  localparam int SHI_U_BIT = 10;
  localparam int ARITH_U_BIT = 8;
  // opcode high bytes and nibbles
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_POP = 8'h01;
  localparam logic [7:0] OP_CLS = 8'h02;
  localparam logic [7:0] OP_JMP8 = 8'h04;
  localparam logic [7:0] OP_PGC = 8'h08;
  localparam logic [7:0] OP_JMP = 8'h2C;
  localparam logic [7:0] OP_GTO = 8'h2D;
  localparam logic [7:0] OP_IRT = 8'h2E;
  localparam logic [7:0] OP_GSB = 8'h2F;
  localparam logic [7:0] OP_POW = 8'h8E;
  localparam logic [5:0] OP6_ADD = 6'h20;
  localparam logic [5:0] OP6_SUB = 6'h21;
  localparam logic [5:0] OP6_MUL = 6'h22;
  localparam logic [6:0] OP7_SHL = 7'h46;
  localparam logic [3:0] NIB_SKIP = 4'h1;
  localparam logic [3:0] NIB_BR = 4'h2;
  localparam logic [3:0] NIB_LU = 4'h3;
  localparam logic [3:0] NIB_ARITH = 4'h8;
  localparam logic [3:0] NIB_IMM6 = 4'h9;
  localparam logic [3:0] NIB_ADD8 = 4'hA;
  localparam logic [3:0] NIB_BYT = 4'hB;
  localparam logic [1:0] TAG_MEM = 2'h1;
  localparam logic [1:0] TAG_CJ8 = 2'h3;
  localparam logic [1:0] BR_CJMP = 2'h0;
  localparam logic [1:0] BR_CGTO = 2'h1;
  typedef enum logic [3:0] {
    SCIS_LU_CPY = 4'h0, SCIS_LU_NSB = 4'h1, SCIS_LU_CPYS = 4'h2, SCIS_LU_CPYU = 4'h3,
    SCIS_LU_NOT = 4'h4, SCIS_LU_AND = 4'h5, SCIS_LU_ORR = 4'h6, SCIS_LU_XOR = 4'h7,
    SCIS_LU_BRA = 4'h8, SCIS_LU_BRO = 4'h9, SCIS_LU_BRX = 4'hA, SCIS_LU_FLP = 4'hC,
    SCIS_LU_LZC = 4'hD
  } scis_lu_t;
  typedef enum logic [1:0] {
    SCIS_RUN = 2'h0,
    SCIS_REQ = 2'h1,
    SCIS_DATA = 2'h2
  } scis_state_t;
endpackage

// ### hdl/scis_logic_unit.sv
`timescale 1ns/1ps
module scis_logic_unit (
  input wire logic [3:0] op_i,
  input wire logic [scis_pkg::DW-1:0] a_i,
  input wire logic [scis_pkg::DW-1:0] b_i,
  output logic [scis_pkg::DW-1:0] res_o,
  output logic ok_o
);
  import scis_pkg::*;

  function automatic logic [DW-1:0] flip(input logic [DW-1:0] v);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < DW; i++)
      r[i] = v[DW-1-i];
    return r;
  endfunction

  function automatic logic [DW-1:0] lead_zeros(input logic [DW-1:0] v);
    logic [DW-1:0] n;
    logic seen;
    n = '0;
    seen = 1'b0;
    for (int i = DW-1; i >= 0; i--)
    begin
      if (v[i])
        seen = 1'b1;
      else if (!seen)
        n = n + DW'(1);
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    ok_o = 1'b1;
    case (op_i)
      SCIS_LU_CPY: res_o = b_i;
      SCIS_LU_NSB: res_o = {~b_i[DW-1], b_i[DW-2:0]};
      SCIS_LU_CPYS: res_o = {{(DW-HALF_W){b_i[HALF_W-1]}}, b_i[HALF_W-1:0]};
      SCIS_LU_CPYU: res_o = {{(DW-HALF_W){1'b0}}, b_i[HALF_W-1:0]};
      SCIS_LU_NOT: res_o = ~b_i;
      SCIS_LU_AND: res_o = a_i & b_i;
      SCIS_LU_ORR: res_o = a_i | b_i;
      SCIS_LU_XOR: res_o = a_i ^ b_i;
      SCIS_LU_BRA: res_o = DW'(&b_i);
      SCIS_LU_BRO: res_o = DW'(|b_i);
      SCIS_LU_BRX: res_o = DW'(^b_i);
      SCIS_LU_FLP: res_o = flip(b_i);
      SCIS_LU_LZC: res_o = lead_zeros(b_i);
      default:
      begin
        res_o = '0;
        ok_o = 1'b0;
      end
    endcase
  end
endmodule // scis_logic_unit

// ### hdl/scis_core.sv
// Operation
// - relative branches add offset to next instruction address; -1 loops forever
// - condition gates only the branch; operand pops always happen
// - A less than zero tests treat A as two's complement
// - A versus B signed or unsigned tests treat both operands alike
// - memory: full read, sign-extended half read, full write, half write
// - address is B plus offset, doubled for full width; odd bases fine
// - memory field layout: 01, half, write, offset, B pop/index, A pop/index
// - register set full-width read into A and write from A, 6-bit index
// - signed immediate shift: left when positive, right when negative, one cycle
// - unsigned immediate shift: one-hot when non-negative, logical right when negative
// - top nibble A adds sign-extended byte immediate to A
// - top nibble B pushes sign-extended byte immediate onto A stack
// - relative jump adds signed B to next instruction address, plain or on A zero test
// - go-to loads PC with B, plain or on A zero test
// - interrupt return loads PC with B and re-enables service logic
// - subroutine call loads PC with B and pushes return address to A
// - stack pop pops every flagged stack at once
// - stack clear clears every flagged stack at once
// - PC push pushes next instruction address onto A stack
// - no-operation does nothing, not even operand pops
// - logic unit: copy, bit reversal, sign bit inversion, leading zero count
// - power gives one shifted by B; variable shifts never go one-hot
`timescale 1ns/1ps
module scis_core (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [scis_pkg::IW-1:0] instr_i,
  input wire logic [scis_pkg::DW-1:0] pc_i,
  input wire logic [scis_pkg::DW-1:0] a_i,
  input wire logic [scis_pkg::DW-1:0] b_i,
  input wire logic [scis_pkg::DW-1:0] mem_rdata_i,
  input wire logic [scis_pkg::DW-1:0] reg_rdata_i,
  output logic instr_ready_o,
  output logic done_o,
  output logic [scis_pkg::DW-1:0] pc_o,
  output logic [scis_pkg::NSTK-1:0] pop_o,
  output logic [scis_pkg::NSTK-1:0] clr_o,
  output logic push_o,
  output logic [scis_pkg::SIW-1:0] push_sel_o,
  output logic [scis_pkg::DW-1:0] push_data_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_half_o,
  output logic [scis_pkg::DW-1:0] mem_addr_o,
  output logic [scis_pkg::DW-1:0] mem_wdata_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [scis_pkg::IM6_W-1:0] reg_addr_o,
  output logic [scis_pkg::DW-1:0] reg_wdata_o,
  output logic isr_reenable_o
);
  import scis_pkg::*;

  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [DW-1:0] sext8(input logic [7:0] v);
    return {{(DW-8){v[7]}}, v};
  endfunction

  function automatic logic [NSTK-1:0] stk_bit(input logic [SIW-1:0] idx);
    return NSTK'(1) << idx;
  endfunction

  // sign of A is its msb, so the less-than-zero test is two's complement
  function automatic logic zero_test(input logic [DW-1:0] a, input logic lt, input logic neg);
    logic r;
    r = lt ? a[DW-1] : (a == '0);
    return r ^ neg;
  endfunction

  // signed distance: left when non-negative, right by magnitude otherwise
  function automatic logic [DW-1:0] shift_dist(input logic [DW-1:0] a, input logic [5:0] d, input logic arith);
    logic [5:0] mag;
    logic [DW:0] ext;
    mag = 6'(-d);
    ext = {arith & a[DW-1], a};
    if (!d[5])
      return a << d[4:0];
    ext = $signed(ext) >>> mag;
    return ext[DW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  scis_state_t state_q, state_d;
  logic ready_q, done_q, push_q, mem_rd_q, mem_wr_q, mem_half_q;
  logic reg_rd_q, reg_wr_q, isr_q, rd_mem_q, rd_half_q;
  logic [DW-1:0] pc_q, push_data_q, mem_addr_q, mem_wdata_q, reg_wdata_q;
  logic [NSTK-1:0] pop_q, clr_q;
  logic [SIW-1:0] push_sel_q, rd_sel_q;
  logic [IM6_W-1:0] reg_addr_q;

  wire logic take;
  wire logic [7:0] op_hi;
  wire logic [3:0] nib;
  wire logic [SIW-1:0] a_idx;
  wire logic [SIW-1:0] b_idx;
  wire logic [IM6_W-1:0] im6;
  wire logic [IM4_W-1:0] im4;
  wire logic [7:0] im8_lo;
  wire logic [7:0] im8_hi;
  assign take = instr_valid_i && state_q == SCIS_RUN;
  assign op_hi = instr_i[IW-1:IW-8];
  assign nib = instr_i[IW-1:IW-4];
  assign a_idx = instr_i[A_LSB +: SIW];
  assign b_idx = instr_i[B_LSB +: SIW];
  assign im6 = instr_i[IM6_LSB +: IM6_W];
  assign im4 = instr_i[IM4_LSB +: IM4_W];
  assign im8_lo = instr_i[IM8_LO_LSB +: 8];
  assign im8_hi = instr_i[IM8_HI_LSB +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic is_nop, is_pop, is_cls, is_jmp8, is_pgc, is_skip, is_cjr, is_cgto;
  wire logic is_jmpr, is_gto, is_irt, is_gsb, is_lu, is_mem, is_add, is_sub;
  wire logic is_mul, is_shlv, is_pow, is_shi, is_reg, is_add8, is_byt, is_cj8;
  assign is_nop = op_hi == OP_NOP;
  assign is_pop = op_hi == OP_POP;
  assign is_cls = op_hi == OP_CLS;
  assign is_jmp8 = op_hi == OP_JMP8;
  assign is_pgc = op_hi == OP_PGC;
  assign is_skip = nib == NIB_SKIP;
  assign is_cjr = nib == NIB_BR && instr_i[11:10] == BR_CJMP;
  assign is_cgto = nib == NIB_BR && instr_i[11:10] == BR_CGTO;
  assign is_jmpr = op_hi == OP_JMP;
  assign is_gto = op_hi == OP_GTO;
  assign is_irt = op_hi == OP_IRT;
  assign is_gsb = op_hi == OP_GSB;
  assign is_lu = nib == NIB_LU;
  assign is_mem = instr_i[IW-1:IW-2] == TAG_MEM;
  assign is_add = instr_i[IW-1:IW-6] == OP6_ADD;
  assign is_sub = instr_i[IW-1:IW-6] == OP6_SUB;
  assign is_mul = instr_i[IW-1:IW-6] == OP6_MUL;
  assign is_shlv = instr_i[IW-1:IW-7] == OP7_SHL;
  assign is_pow = op_hi == OP_POW;
  assign is_shi = nib == NIB_IMM6 && !instr_i[11];
  assign is_reg = nib == NIB_IMM6 && instr_i[11];
  assign is_add8 = nib == NIB_ADD8;
  assign is_byt = nib == NIB_BYT;
  assign is_cj8 = instr_i[IW-1:IW-2] == TAG_CJ8;

  // operand fields present per format
  wire logic has_b, has_a;
  wire logic [NSTK-1:0] opnd_pops, pop_d;
  assign has_b = is_pgc || is_skip || nib == NIB_BR || is_lu || is_mem || nib == NIB_ARITH;
  assign has_a = has_b || nib == NIB_IMM6 || is_add8 || is_byt || is_cj8;
  assign opnd_pops = ((has_a && instr_i[A_POP_BIT]) ? stk_bit(a_idx) : '0)
                   | ((has_b && instr_i[B_POP_BIT]) ? stk_bit(b_idx) : '0);
  // pops never depend on the branch outcome
  assign pop_d = is_pop ? im8_lo : (is_nop ? '0 : opnd_pops);

  ////////////////////////////////////////////////////////////////////////////
  // branch conditions and targets
  wire logic ab_test, sk_hit, c2_hit, cj8_hit;
  wire logic [DW-1:0] pc_seq, pc_d;
  assign ab_test = instr_i[COND_L_BIT]
                 ? (instr_i[SK_U_BIT] ? (a_i < b_i) : ($signed(a_i) < $signed(b_i)))
                 : (a_i == b_i);
  assign sk_hit = is_skip && (ab_test ^ instr_i[COND_N_BIT]);
  assign c2_hit = zero_test(a_i, instr_i[COND_L_BIT], instr_i[COND_N_BIT]);
  assign cj8_hit = is_cj8 && zero_test(a_i, instr_i[CJ8_L_BIT], instr_i[CJ8_N_BIT]);
  assign pc_seq = pc_i + DW'(1);
  assign pc_d = is_jmp8 ? pc_seq + sext8(im8_lo)
              : cj8_hit ? pc_seq + sext8(im8_hi)
              : sk_hit ? pc_seq + (instr_i[SK_TWO_BIT] ? DW'(2) : DW'(1))
              : (is_jmpr || (is_cjr && c2_hit)) ? pc_seq + b_i
              : (is_gto || is_irt || is_gsb || (is_cgto && c2_hit)) ? b_i
              : pc_seq;

  ////////////////////////////////////////////////////////////////////////////
  // results; variable shift distance is B's low six bits, so large B wraps
  wire logic [DW-1:0] lu_res, ar_res, shi_res, push_now_val, rd_val, push_val;
  wire logic [2*DW-1:0] mul_full;
  wire logic lu_ok, push_now, rd_issue, rd_back;
  scis_logic_unit u_lu (
    .op_i(instr_i[11:8]),
    .a_i(a_i),
    .b_i(b_i),
    .res_o(lu_res),
    .ok_o(lu_ok)
  );
  assign mul_full = a_i * b_i;
  assign ar_res = is_add ? a_i + b_i
                : is_sub ? a_i - b_i
                : is_mul ? mul_full[DW-1:0]
                : is_shlv ? shift_dist(a_i, b_i[5:0], !instr_i[ARITH_U_BIT])
                : DW'(1) << b_i[4:0];
  assign shi_res = !instr_i[SHI_U_BIT] ? shift_dist(a_i, im6, 1'b1)
                 : im6[5] ? shift_dist(a_i, im6, 1'b0)
                 : DW'(1) << im6[4:0];
  assign push_now_val = (is_pgc || is_gsb) ? pc_seq
                      : is_lu ? lu_res
                      : nib == NIB_ARITH ? ar_res
                      : is_shi ? shi_res
                      : is_add8 ? a_i + sext8(im8_hi)
                      : sext8(im8_hi);
  assign push_now = take && (is_pgc || is_gsb || (is_lu && lu_ok) || is_add || is_sub || is_mul
                    || is_shlv || is_pow || is_shi || is_add8 || is_byt);
  // half reads fill the top of the stack word with the sign
  assign rd_val = !rd_mem_q ? reg_rdata_i
                : rd_half_q ? {{(DW-HALF_W){mem_rdata_i[HALF_W-1]}}, mem_rdata_i[HALF_W-1:0]}
                : mem_rdata_i;
  assign rd_back = state_q == SCIS_DATA;
  assign push_val = rd_back ? rd_val : push_now_val;
  assign rd_issue = take && ((is_mem && !instr_i[MEM_WR_BIT]) || (is_reg && !instr_i[REG_W_BIT]));

  // memory address: offset counts half words, doubled for full words
  wire logic [DW-1:0] mem_addr_d;
  assign mem_addr_d = b_i + (instr_i[MEM_HALF_BIT] ? DW'(im4) : DW'({im4, 1'b0}));

  ////////////////////////////////////////////////////////////////////////////
  // reads stall the block until the returned word is pushed
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SCIS_RUN:
      begin
        if (rd_issue)
          state_d = SCIS_REQ;
      end
      SCIS_REQ: state_d = SCIS_DATA;
      SCIS_DATA: state_d = SCIS_RUN;
      default: state_d = SCIS_RUN;
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= SCIS_RUN;
      ready_q <= 1'b1;
      rd_sel_q <= '0;
      rd_mem_q <= 1'b0;
      rd_half_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ready_q <= state_d == SCIS_RUN;
      if (rd_issue)
      begin
        rd_sel_q <= a_idx;
        rd_mem_q <= is_mem;
        rd_half_q <= instr_i[MEM_HALF_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      done_q <= 1'b0;
      pc_q <= '0;
      pop_q <= '0;
      clr_q <= '0;
      isr_q <= 1'b0;
    end
    else
    begin
      done_q <= take;
      if (take)
        pc_q <= pc_d;
      pop_q <= take ? pop_d : '0;
      clr_q <= (take && is_cls) ? im8_lo : '0;
      isr_q <= take && is_irt;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      push_q <= 1'b0;
      push_sel_q <= '0;
      push_data_q <= '0;
    end
    else
    begin
      push_q <= push_now || rd_back;
      if (push_now || rd_back)
      begin
        push_sel_q <= rd_back ? rd_sel_q : a_idx;
        push_data_q <= push_val;
      end
    end
  end

  // memory and register set strobes last one cycle
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_half_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
      reg_rd_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_addr_q <= '0;
      reg_wdata_q <= '0;
    end
    else
    begin
      mem_rd_q <= take && is_mem && !instr_i[MEM_WR_BIT];
      mem_wr_q <= take && is_mem && instr_i[MEM_WR_BIT];
      reg_rd_q <= take && is_reg && !instr_i[REG_W_BIT];
      reg_wr_q <= take && is_reg && instr_i[REG_W_BIT];
      if (take && is_mem)
      begin
        mem_half_q <= instr_i[MEM_HALF_BIT];
        mem_addr_q <= mem_addr_d;
        mem_wdata_q <= a_i;
      end
      if (take && is_reg)
      begin
        reg_addr_q <= im6;
        reg_wdata_q <= a_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign instr_ready_o = ready_q;
  assign done_o = done_q;
  assign pc_o = pc_q;
  assign pop_o = pop_q;
  assign clr_o = clr_q;
  assign push_o = push_q;
  assign push_sel_o = push_sel_q;
  assign push_data_o = push_data_q;
  assign mem_rd_o = mem_rd_q;
  assign mem_wr_o = mem_wr_q;
  assign mem_half_o = mem_half_q;
  assign mem_addr_o = mem_addr_q;
  assign mem_wdata_o = mem_wdata_q;
  assign reg_rd_o = reg_rd_q;
  assign reg_wr_o = reg_wr_q;
  assign reg_addr_o = reg_addr_q;
  assign reg_wdata_o = reg_wdata_q;
  assign isr_reenable_o = isr_q;

  ////////////////////////////////////////////////////////////////////////////
  rel_branch_a: assert property (take && is_jmp8 |=> pc_o == $past(pc_i) + DW'(1) + sext8($past(im8_lo)))
    else $error("relative branch target wrong");
  cond_pop_a: assert property (take && is_cj8 && instr_i[A_POP_BIT] && !cj8_hit |=> pop_o == stk_bit($past(a_idx)))
    else $error("pop lost on untaken branch");
  sign_test_a: assert property (take && is_cj8 && instr_i[CJ8_L_BIT] && !instr_i[CJ8_N_BIT] && a_i[DW-1]
    |=> pc_o == $past(pc_seq) + sext8($past(im8_hi)))
    else $error("negative A did not branch");
  mem_addr_a: assert property (take && is_mem && !instr_i[MEM_HALF_BIT]
    |=> mem_addr_o == $past(b_i) + DW'({$past(im4), 1'b0}))
    else $error("full width address wrong");
  half_read_a: assert property (mem_rd_o && mem_half_o |-> ##1 !push_o ##1 push_o
    && push_data_o[DW-1:HALF_W] == {(DW-HALF_W){push_data_o[HALF_W-1]}})
    else $error("half read not sign extended");
  byte_push_a: assert property (take && is_byt |=> push_o && push_sel_o == $past(a_idx)
    && push_data_o == sext8($past(im8_hi)))
    else $error("immediate byte push wrong");
  nop_quiet_a: assert property (take && is_nop |=> pop_o == '0 && !push_o && !mem_wr_o && pc_o == $past(pc_seq))
    else $error("nop had an effect");
  call_push_a: assert property (take && is_gsb |=> pc_o == $past(b_i) && push_o
    && push_data_o == $past(pc_i) + DW'(1))
    else $error("call target or return address wrong");
  irt_a: assert property (take && is_irt |=> isr_reenable_o && pc_o == $past(b_i))
    else $error("interrupt return wrong");
  pop_all_a: assert property (take && is_pop |=> pop_o == $past(im8_lo) && !push_o)
    else $error("stack pop vector wrong");
endmodule // scis_core

// ### verif/stack_core_instruction_semantics_test.sv
`timescale 1ns/1ps
module stack_core_instruction_semantics_test;
  import scis_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [IW-1:0] instr_i = '0;
  logic [DW-1:0] pc_i = '0;
  logic [DW-1:0] a_i = '0;
  logic [DW-1:0] b_i = '0;
  logic [DW-1:0] mem_rdata_i = '0;
  logic [DW-1:0] reg_rdata_i = '0;
  logic instr_ready_o, done_o, push_o, mem_rd_o, mem_wr_o, mem_half_o, reg_rd_o, reg_wr_o, isr_reenable_o;
  logic [DW-1:0] pc_o, push_data_o, mem_addr_o, mem_wdata_o, reg_wdata_o;
  logic [NSTK-1:0] pop_o, clr_o;
  logic [SIW-1:0] push_sel_o;
  logic [IM6_W-1:0] reg_addr_o;
  int fails = 0;
  int checks = 0;

  always #4 mclk_i = ~mclk_i;

  scis_core scis_core_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .pc_i(pc_i), .a_i(a_i), .b_i(b_i), .mem_rdata_i(mem_rdata_i),
    .reg_rdata_i(reg_rdata_i), .instr_ready_o(instr_ready_o), .done_o(done_o), .pc_o(pc_o),
    .pop_o(pop_o), .clr_o(clr_o), .push_o(push_o), .push_sel_o(push_sel_o), .push_data_o(push_data_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_half_o(mem_half_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o),
    .reg_wdata_o(reg_wdata_o), .isr_reenable_o(isr_reenable_o));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (fails == 0 && checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // offer one instruction; return just after the taking edge has landed
  task automatic issue(input logic [15:0] ins, input logic [31:0] pc, input logic [31:0] a, input logic [31:0] b);
    @(posedge mclk_i);
    instr_valid_i <= 1'b1;
    instr_i <= ins;
    pc_i <= pc;
    a_i <= a;
    b_i <= b;
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask

  task automatic chk_push(input logic [31:0] d, input logic [2:0] sel);
    chk("push_o", 32'h1, 32'(push_o));
    chk("push_data_o", d, push_data_o);
    chk("push_sel_o", 32'(sel), 32'(push_sel_o));
  endtask

  // read results land later; bounded wait keeps a lost push from hanging
  task automatic wait_push(input logic [31:0] d, input logic [2:0] sel);
    int n;
    n = 0;
    while (push_o !== 1'b1 && n < 4)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk("push_delay", 32'h2, 32'(n));
    chk_push(d, sel);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_rel;
    issue(16'h0400, 32'h64, '0, '0);
    chk("pc_o", 32'h65, pc_o);
    issue(16'h04FF, 32'h64, '0, '0);
    chk("pc_o", 32'h64, pc_o);
  endtask

  task automatic t_cond;
    issue(16'hE05A, 32'h100, 32'h80000000, '0);
    chk("pc_o", 32'h106, pc_o);
    chk("pop_o", 32'h4, 32'(pop_o));
    issue(16'hE05A, 32'h100, 32'h1, '0);
    chk("pc_o", 32'h101, pc_o);
    chk("pop_o", 32'h4, 32'(pop_o));
    issue(16'h1210, 32'h100, 32'hFFFFFFFF, 32'h1);
    chk("pc_o", 32'h102, pc_o);
    issue(16'h1610, 32'h100, 32'hFFFFFFFF, 32'h1);
    chk("pc_o", 32'h101, pc_o);
    issue(16'h1810, 32'h100, 32'h7, 32'h7);
    chk("pc_o", 32'h103, pc_o);
  endtask

  task automatic t_mem;
    mem_rdata_i <= 32'h12348001;
    issue(16'h4392, '0, 32'hCAFE0001, 32'h5);
    chk("mem_rd_o", 32'h1, 32'(mem_rd_o));
    chk("mem_addr_o", 32'hB, mem_addr_o);
    chk("instr_ready_o", 32'h0, 32'(instr_ready_o));
    chk("pop_o", 32'h2, 32'(pop_o));
    wait_push(32'h12348001, 3'd2);
    issue(16'h6392, '0, 32'hCAFE0001, 32'h5);
    chk("mem_addr_o", 32'h8, mem_addr_o);
    wait_push(32'hFFFF8001, 3'd2);
    issue(16'h5392, '0, 32'hCAFE0001, 32'h5);
    chk("mem_wr_o", 32'h1, 32'(mem_wr_o));
    chk("mem_half_o", 32'h0, 32'(mem_half_o));
    chk("mem_wdata_o", 32'hCAFE0001, mem_wdata_o);
    chk("push_o", 32'h0, 32'(push_o));
    issue(16'h7392, '0, 32'hCAFE0001, 32'h5);
    chk("mem_half_o", 32'h1, 32'(mem_half_o));
    chk("mem_addr_o", 32'h8, mem_addr_o);
    chk("mem_wdata_lo", 32'h1, 32'(mem_wdata_o[15:0]));
  endtask

  task automatic t_reg;
    reg_rdata_i <= 32'h600DF00D;
    issue(16'h9FF3, '0, 32'h13579BDF, '0);
    chk("reg_wr_o", 32'h1, 32'(reg_wr_o));
    chk("reg_addr_o", 32'h3F, 32'(reg_addr_o));
    chk("reg_wdata_o", 32'h13579BDF, reg_wdata_o);
    issue(16'h9BF3, '0, '0, '0);
    chk("reg_rd_o", 32'h1, 32'(reg_rd_o));
    wait_push(32'h600DF00D, 3'd3);
  endtask

  // instruction, a, b, expected push data; each result goes to the A stack of its word
  task automatic t_table;
    logic [15:0] ins [18] = '{16'h9040, 16'h93C0, 16'h9450, 16'h97C0, 16'hA800, 16'hA7F0, 16'hBFF0, 16'h3C10,
      16'h3110, 16'h3D10, 16'h3010, 16'h8E10, 16'h8C10, 16'h8C10, 16'h8410, 16'h8810, 16'h3410, 16'h80A9};
    logic [31:0] av [18] = '{32'h100, 32'h100, 32'h100, 32'h80000000, 32'hA, 32'hA, 0, 0, 0, 0, 0, 0, 32'h3,
      32'h1, 32'h5, 32'h3, 0, 32'h7};
    logic [31:0] bv [18] = '{0, 0, 0, 0, 0, 0, 0, 32'h1, 32'h1, 32'h10000, 32'h5A, 32'h5, 32'h5, 32'h1F, 32'h7,
      32'h5, 32'h0F0F0F0F, 32'h9};
    logic [31:0] ex [18] = '{32'h1000, 32'h10, 32'h20, 32'h08000000, 32'hFFFFFF8A, 32'h89, 32'hFFFFFFFF,
      32'h80000000, 32'h80000001, 32'hF, 32'h5A, 32'h20, 32'h60, 32'h80000000, 32'hFFFFFFFE, 32'hF,
      32'hF0F0F0F0, 32'h10};
    for (int i = 0; i < 18; i++)
    begin
      issue(ins[i], 32'h200, av[i], bv[i]);
      chk_push(ex[i], ins[i][2:0]);
    end
    chk("pop_o", 32'h6, 32'(pop_o));
    chk("done_o", 32'h1, 32'(done_o));
  endtask

  task automatic t_branch;
    issue(16'h2C00, 32'h100, '0, 32'hFFFFFFFD);
    chk("pc_o", 32'hFE, pc_o);
    issue(16'h2010, 32'h100, '0, 32'h5);
    chk("pc_o", 32'h106, pc_o);
    issue(16'h2510, 32'h100, '0, 32'h1234);
    chk("pc_o", 32'h101, pc_o);
    issue(16'h2610, 32'h100, 32'h80000000, 32'h1234);
    chk("pc_o", 32'h1234, pc_o);
    issue(16'h2D00, 32'h100, '0, 32'h1234);
    chk("pc_o", 32'h1234, pc_o);
    issue(16'h2E00, 32'h100, '0, 32'h4321);
    chk("pc_o", 32'h4321, pc_o);
    chk("isr_reenable_o", 32'h1, 32'(isr_reenable_o));
    issue(16'h2F04, 32'h100, '0, 32'h800);
    chk("pc_o", 32'h800, pc_o);
    chk_push(32'h101, 3'd4);
  endtask

  task automatic t_stack;
    issue(16'h01A5, 32'h100, '0, '0);
    chk("pop_o", 32'hA5, 32'(pop_o));
    issue(16'h02FF, 32'h100, '0, '0);
    chk("clr_o", 32'hFF, 32'(clr_o));
    issue(16'h0806, 32'h100, '0, '0);
    chk_push(32'h101, 3'd6);
    issue(16'h00FF, 32'h100, '0, '0);
    chk("pop_o", 32'h0, 32'(pop_o));
    chk("push_o", 32'h0, 32'(push_o));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge mclk_i);
    chk("instr_ready_o", 32'h1, 32'(instr_ready_o));
    sys_rst_i <= 1'b0;
    t_rel();
    t_cond();
    t_mem();
    t_reg();
    t_table();
    t_branch();
    t_stack();
    give_verdict();
  end

  // whole run needs about a hundred cycles; this is far past it
  initial
  begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule // stack_core_instruction_semantics_test
